// [design/vad_defs.vh]
`ifndef VAD_DEFS_VH
`define VAD_DEFS_VH
// register indices on the plain register port
`define VAD_ADDR_W        4
`define VAD_REG_CFG1      4'h0
`define VAD_REG_CFG2      4'h1
`define VAD_REG_FCR       4'h2
`define VAD_REG_STATUS    4'h3
// cfg1 fields
`define VAD_CFG1_IRQ_LSB  0
`define VAD_CFG1_IRQ_MSB  2
`define VAD_CFG1_BR_LSB   3
`define VAD_CFG1_BR_MSB   4
`define VAD_CFG1_ROR      5
`define VAD_CFG1_CARRY    6
`define VAD_CFG1_SYSCTL   7
// cfg2 fields
`define VAD_CFG2_USER     0
`define VAD_CFG2_LED_GRN  1
`define VAD_CFG2_DMA_LSB  2
`define VAD_CFG2_DMA_MSB  3
`define VAD_CFG2_IRQ_EN   4
// fcr fields
`define VAD_FCR_M0        0
`define VAD_FCR_M1        1
`define VAD_FCR_M2        2
// reset values
`define VAD_CFG1_RST      8'h01
`define VAD_CFG2_RST      8'h00
`define VAD_FCR_RST       8'h00
// address modifier codes and window
`define VAD_AM_SUPER      6'h2d
`define VAD_AM_USER       6'h29
`define VAD_WIN_LSB       9
`define VAD_BASE_DEFAULT  7'h10
// edges after reset release before the synchronised strap is trusted
`define VAD_STRAP_WAIT    3'd5
`endif

// [design/vad_sync3.v]
`timescale 1ns/100ps
`include "vad_defs.vh"
// three-stage pin synchroniser; a change counts once stages two and three agree
module vad_sync3 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         ce,
    input  wire [W-1:0] pin,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    genvar i;
    // ====================================================
    // per-bit chain
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else if (ce) begin
                    s1_reg[i] <= pin[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        q[i] <= s3_reg[i]; // hold last agreed value on disagreement
                    end
                end
            end
        end
    endgenerate
endmodule // vad_sync3

// [design/vad_access_decode.v]
// Operation
// - reset adopts strapped privilege mode
// - cfg2 mode bit overrides strap afterwards
// - supervisor accepts only short I/O 0x2d
// - user accepts 0x29 or 0x2d
// - strap default supervisor
// - single 512-byte window decoded
// - external compare inputs when straps removed
// - default strap base is 0x2000
// - drive six-bit modifier during dma mastership
// - modifier built from straps and function bits
// - interrupt routed to one of seven levels
// - one of four bus request levels
// - release-on-request enable bit
// - automatic carry cycle option bit
// - instrument-bus system controller enable
// - sysfail lamp red or green select
// - dma transfer mode setting
// - interrupt released on register access
// - address-only cycles not register accesses
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "vad_defs.vh"
module vad_access_decode (
    input  wire        clk,
    input  wire        nrst,
    input  wire        ce,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // straps and pins
    input  wire        access_mode_strap,
    input  wire        base_strap_present,
    input  wire [6:0]  base_address_strap_block,
    input  wire [6:0]  compare_addr_input,
    input  wire        am5_strap,
    input  wire        am3_strap,
    input  wire        am0_polarity_strap,
    // backplane slave side
    input  wire        as_n,
    input  wire        ds_n,
    input  wire [5:0]  am_in,
    input  wire [15:0] addr_in,
    output wire        slave_sel,
    output wire        reg_access,
    // dma master side
    input  wire        dma_master,
    output reg  [5:0]  am_out,
    output reg         am_oe,
    // interrupt request from the core
    input  wire        irq_event,
    output reg  [6:0]  irq_n_out,
    output reg  [6:0]  irq_oe,
    input  wire        bus_req,
    output reg  [3:0]  br_oe,
    output wire        ror_enable,
    output wire        carry_enable,
    output wire        sys_ctl_enable,
    output reg         led_green,
    output wire [1:0]  dma_mode
);
    // ====================================================
    // synchronised pins
    wire        as_s;
    wire        ds_s;
    wire [5:0]  am_s;
    wire [15:0] addr_s;
    wire [6:0]  ca_s;
    wire        strap_s;
    wire        pres_s;
    wire [6:0]  bst_s;
    wire [3:0]  amst_s;

    vad_sync3 #(.W(44)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .pin  ({~as_n, ~ds_n, am_in, addr_in, compare_addr_input, access_mode_strap,
                base_strap_present, base_address_strap_block, am5_strap, am3_strap,
                am0_polarity_strap, 1'b0}),
        .q    ({as_s, ds_s, am_s, addr_s, ca_s, strap_s, pres_s, bst_s, amst_s})
    );

    // ====================================================
    // configuration registers
    reg [7:0] cfg1_reg;
    reg [7:0] cfg2_reg;
    reg [7:0] fcr_reg;
    reg       strap_seen_reg;   // strap sampled once after reset release
    reg [2:0] strap_cnt_reg;    // waits out the synchroniser after release
    reg       irq_pend_reg;
    reg       sel_d_reg;

    wire user_mode = cfg2_reg[`VAD_CFG2_USER];

    // strap is a pin level, so it is caught by a clocked load after release,
    // never by the asynchronous reset itself
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg1_reg       <= `VAD_CFG1_RST;
            cfg2_reg       <= `VAD_CFG2_RST;
            fcr_reg        <= `VAD_FCR_RST;
            strap_seen_reg <= 1'b0;
            strap_cnt_reg  <= 3'd0;
        end else if (ce) begin
            // the synchroniser output is still its reset value for a few edges,
            // so the strap is only taken once the chain has filled
            if (!strap_seen_reg) begin
                if (strap_cnt_reg == `VAD_STRAP_WAIT) begin
                    // strap high means user; unfitted strap reads low = supervisor
                    cfg2_reg[`VAD_CFG2_USER] <= strap_s;
                    strap_seen_reg           <= 1'b1;
                end else begin
                    strap_cnt_reg <= strap_cnt_reg + 3'd1;
                end
            end
            if (reg_wr) begin
                case (reg_addr)
                    `VAD_REG_CFG1: cfg1_reg <= reg_wdata;
                    `VAD_REG_CFG2: cfg2_reg <= reg_wdata;
                    `VAD_REG_FCR:  fcr_reg  <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ====================================================
    // register read, data one cycle after the strobe
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            if (reg_rd) begin
                case (reg_addr)
                    `VAD_REG_CFG1:   reg_rdata <= cfg1_reg;
                    `VAD_REG_CFG2:   reg_rdata <= cfg2_reg;
                    `VAD_REG_FCR:    reg_rdata <= fcr_reg;
                    `VAD_REG_STATUS: reg_rdata <= {4'h0, pres_s, irq_pend_reg, sel_d_reg,
                                                   user_mode};
                    default:         reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ====================================================
    // slave decode
    // straps win when fitted; the compare lines are ignored while the strap block is present
    wire [6:0] base = pres_s ? bst_s : ca_s;
    wire am_ok = (am_s == `VAD_AM_SUPER) ||
                 (user_mode && (am_s == `VAD_AM_USER));
    wire win_hit = (addr_s[15:`VAD_WIN_LSB] == base);

    assign slave_sel  = as_s && am_ok && win_hit && !dma_master;
    // address-only cycle has no data strobe and is never a register access
    assign reg_access = slave_sel && ds_s;

    // ====================================================
    // interrupt, released on any onboard register access
    reg acc_d_reg;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_pend_reg <= 1'b0;
            acc_d_reg    <= 1'b0;
            sel_d_reg    <= 1'b0;
        end else if (ce) begin
            acc_d_reg <= reg_access;
            sel_d_reg <= slave_sel;
            // new event wins over a release in the same cycle
            if (irq_event && cfg2_reg[`VAD_CFG2_IRQ_EN]) begin
                irq_pend_reg <= 1'b1;
            end else if (reg_access && !acc_d_reg) begin
                irq_pend_reg <= 1'b0;
            end
        end
    end

    // ====================================================
    // level routing for interrupt and bus request (open drain)
    wire [2:0] irq_lvl = cfg1_reg[`VAD_CFG1_IRQ_MSB:`VAD_CFG1_IRQ_LSB];
    wire [1:0] br_lvl  = cfg1_reg[`VAD_CFG1_BR_MSB:`VAD_CFG1_BR_LSB];
    genvar k;
    generate
        for (k = 0; k < 7; k = k + 1) begin : g_irq
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    irq_oe[k]    <= 1'b0;
                    irq_n_out[k] <= 1'b0;
                end else if (ce) begin
                    // level 0 code leaves every line idle
                    irq_oe[k]    <= irq_pend_reg && (irq_lvl == k + 1);
                    irq_n_out[k] <= 1'b0;
                end
            end
        end
        for (k = 0; k < 4; k = k + 1) begin : g_br
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    br_oe[k] <= 1'b0;
                end else if (ce) begin
                    br_oe[k] <= bus_req && (br_lvl == k);
                end
            end
        end
    endgenerate

    assign ror_enable     = cfg1_reg[`VAD_CFG1_ROR];
    assign carry_enable   = cfg1_reg[`VAD_CFG1_CARRY];
    assign sys_ctl_enable = cfg1_reg[`VAD_CFG1_SYSCTL];
    assign dma_mode       = cfg2_reg[`VAD_CFG2_DMA_MSB:`VAD_CFG2_DMA_LSB];

    // ====================================================
    // master address modifier, registered for clean backplane timing
    wire am1 = fcr_reg[`VAD_FCR_M0];
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            am_out    <= 6'h00;
            am_oe     <= 1'b0;
            led_green <= 1'b0;
        end else if (ce) begin
            led_green <= cfg2_reg[`VAD_CFG2_LED_GRN];
            am_oe     <= dma_master;
            // polarity strap high keeps am0 equal to am1, low inverts it
            am_out    <= {amst_s[3], fcr_reg[`VAD_FCR_M1], amst_s[2],
                          fcr_reg[`VAD_FCR_M2], am1,
                          am1 ^ ~amst_s[1]};
        end
    end
endmodule // vad_access_decode

// [dv/vad_host_bfm.sv]
`timescale 1ns/100ps
// =========
// backplane host: one addressed cycle while req is high
module vad_host_bfm (
    input  wire        clk,
    input  wire        nrst,
    input  wire        req,
    input  wire        ds,
    input  wire [5:0]  am,
    input  wire [15:0] addr,
    output reg         as_n,
    output reg         ds_n,
    output reg  [5:0]  am_in,
    output reg  [15:0] addr_in
);
    // released lines float to the terminator level, never the last value
    always @(posedge clk or negedge nrst) begin
        if (!nrst || !req) begin
            as_n    <= 1'b1;
            ds_n    <= 1'b1;
            am_in   <= 6'h3f;
            addr_in <= 16'hffff;
        end else begin
            as_n    <= 1'b0;
            ds_n    <= !ds;
            am_in   <= am;
            addr_in <= addr;
        end
    end
endmodule // vad_host_bfm

// [dv/vad_access_sva.sv]
`timescale 1ns/100ps
// =========
// decode checker
module vad_access_sva (
    input wire       clk,
    input wire       nrst,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       am5_strap,
    input wire       am3_strap,
    input wire       am0_polarity_strap,
    input wire       slave_sel,
    input wire       reg_access,
    input wire       dma_master,
    input wire [5:0] am_out,
    input wire       am_oe,
    input wire       irq_event,
    input wire [6:0] irq_oe,
    input wire [3:0] br_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // an access with no fresh event behind it must drop the request
    sequence s_acc_quiet;
        ($rose(reg_access) && !irq_event) ##1 !irq_event;
    endsequence
    a_sel_no_dma: assert property (slave_sel |-> !dma_master)
        else $error("select while mastering");
    a_acc_sel: assert property (reg_access |-> slave_sel)
        else $error("access without select");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    a_am_oe_lag: assert property (am_oe == $past(dma_master))
        else $error("modifier enable timing");
    a_am_strap_bits: assert property (am_oe |-> am_out[5] == am5_strap && am_out[3] == am3_strap)
        else $error("modifier strap bits");
    a_am_low_pol: assert property (am_oe |-> am_out[0] == (am_out[1] ^ !am0_polarity_strap))
        else $error("modifier low bit polarity");
    a_irq_one: assert property ($onehot0(irq_oe))
        else $error("several interrupt levels");
    a_br_one: assert property ($onehot0(br_oe))
        else $error("several request levels");
    a_irq_drop: assert property (s_acc_quiet |=> irq_oe == 7'h00)
        else $error("interrupt kept after access");
endmodule // vad_access_sva
bind vad_access_decode vad_access_sva u_sva (.*);

// [dv/tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
    reg         clk, nrst, ce, reg_wr, reg_rd, access_mode_strap, base_strap_present;
    reg         am5_strap, am3_strap, am0_polarity_strap, dma_master, irq_event, bus_req;
    reg         h_req, h_ds;
    reg  [3:0]  reg_addr;
    reg  [7:0]  reg_wdata, d;
    reg  [6:0]  base_address_strap_block, compare_addr_input;
    reg  [5:0]  h_am;
    reg  [15:0] h_addr;
    wire [7:0]  reg_rdata;
    wire [5:0]  am_in, am_out;
    wire [15:0] addr_in;
    wire [6:0]  irq_n_out, irq_oe;
    wire [3:0]  br_oe;
    wire [1:0]  dma_mode;
    wire        as_n, ds_n, slave_sel, reg_access, am_oe, ror_enable, carry_enable;
    wire        sys_ctl_enable, led_green;
    int         fail_count, samples_checked, k;
    // modifier expected per function bits 7..0
    localparam [47:0] AM_TBL = {6'h3e, 6'h3d, 6'h2e, 6'h2d, 6'h3a, 6'h39, 6'h2a, 6'h29};
    vad_access_decode dut (.*);
    vad_host_bfm u_host (.clk(clk), .nrst(nrst), .req(h_req), .ds(h_ds), .am(h_am),
        .addr(h_addr), .as_n(as_n), .ds_n(ds_n), .am_in(am_in), .addr_in(addr_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // =========
    // bus tasks
    task wr(input [3:0] a, input [7:0] v);
        @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [7:0] v);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // synchronisers need a few cycles, so both phases wait eight
    task cyc(input [5:0] m, input [15:0] a, input ds, input es);
        @(posedge clk); h_am <= m; h_addr <= a; h_ds <= ds; h_req <= 1'b1;
        repeat (8) @(posedge clk);
        #1 `CHK(slave_sel, es)
        `CHK(reg_access, es & ds)
        h_req <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task do_reset;
        nrst <= 1'b0; repeat (8) @(posedge clk); nrst <= 1'b1; repeat (8) @(posedge clk);
    endtask
    task test_done;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // =========
    // scenarios
    task t_mode;
        rd(4'h3, d); `CHK(d & 8'h09, 8'h08)
        cyc(6'h29, 16'h2000, 1, 0);
        cyc(6'h2d, 16'h2000, 1, 1);
        cyc(6'h2d, 16'h21fe, 0, 1);
        wr(4'h1, 8'h01);
        cyc(6'h29, 16'h21fe, 1, 1);
        cyc(6'h39, 16'h2000, 1, 0);
        cyc(6'h2d, 16'h2200, 1, 0);
        // straps pulled while the compare lines carry another base
        @(posedge clk); base_strap_present <= 1'b0; compare_addr_input <= 7'h55;
        base_address_strap_block <= 7'h2a;
        cyc(6'h2d, 16'haa00, 1, 1);
        cyc(6'h2d, 16'h2000, 1, 0);
        @(posedge clk); base_strap_present <= 1'b1; base_address_strap_block <= 7'h10;
        compare_addr_input <= 7'h6f;
        $display("mode and window test done");
    endtask
    task t_am;
        @(posedge clk); dma_master <= 1'b1;
        for (k = 0; k < 8; k++) begin
            wr(4'h2, k[7:0]);
            settle(2); `CHK(am_out, AM_TBL[k*6 +: 6])
            `CHK(am_oe, 1'b1)
        end
        @(posedge clk); dma_master <= 1'b0;
        settle(2); @(posedge clk); am5_strap <= 1'b0; am3_strap <= 1'b0; am0_polarity_strap <= 1'b1;
        settle(8); @(posedge clk); dma_master <= 1'b1;
        settle(8); `CHK(am_out, 6'h17)
        @(posedge clk); dma_master <= 1'b0;
        settle(2); @(posedge clk); am5_strap <= 1'b1; am3_strap <= 1'b1; am0_polarity_strap <= 1'b0;
        $display("modifier test done");
    endtask
    task t_irq;
        wr(4'h1, 8'h11);
        for (k = 1; k < 8; k++) begin
            wr(4'h0, k[7:0]);
            @(posedge clk); irq_event <= 1'b1;
            @(posedge clk); irq_event <= 1'b0;
            settle(2); `CHK(irq_oe, 7'h01 << (k - 1))
            `CHK(irq_n_out, 7'h00)
            cyc(6'h2d, 16'h2000, 1, 1); `CHK(irq_oe, 7'h00)
        end
        $display("interrupt test done");
    endtask
    task t_cfg;
        for (k = 0; k < 4; k++) begin
            wr(4'h0, {3'h7, k[1:0], 3'h0});
            @(posedge clk); bus_req <= 1'b1;
            settle(2); `CHK(br_oe, 4'h1 << k)
            `CHK({ror_enable, carry_enable, sys_ctl_enable}, 3'h7)
            @(posedge clk); bus_req <= 1'b0;
        end
        wr(4'h0, 8'h08); settle(2);
        `CHK({ror_enable, carry_enable, sys_ctl_enable}, 3'h0)
        wr(4'h1, 8'h0e); settle(2); `CHK({led_green, dma_mode}, 3'h7)
        wr(4'h1, 8'h04); settle(2); `CHK({led_green, dma_mode}, 3'h1)
        // clock enable low: a write must not land
        @(posedge clk); ce <= 1'b0;
        wr(4'h1, 8'h0e);
        @(posedge clk); ce <= 1'b1;
        settle(2); `CHK({led_green, dma_mode}, 3'h1)
        rd(4'h9, d); `CHK(d, 8'h00)
        $display("option test done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done;
    end
    initial begin
        {nrst, reg_wr, reg_rd, access_mode_strap, am0_polarity_strap} = 5'h00;
        {dma_master, irq_event, bus_req, h_req, h_ds} = 5'h00;
        {ce, base_strap_present, am5_strap, am3_strap} = 4'hf;
        reg_addr = 4'h0; reg_wdata = 8'h00; h_am = 6'h00; h_addr = 16'h0000;
        base_address_strap_block = 7'h10; compare_addr_input = 7'h6f;
        do_reset;
        t_mode;
        t_am;
        t_irq;
        t_cfg;
        @(posedge clk); access_mode_strap <= 1'b1;
        do_reset;
        rd(4'h3, d); `CHK(d[0], 1'b1)
        cyc(6'h29, 16'h2000, 1, 1);
        $display("strap reset test done");
        test_done;
    end
endmodule // tb
